/* design/bstap_ctrl.sv */
// Test access port controller: state machine, instruction register and the
// boundary-scan, boundary-control, bypass and identification registers.
// Assumes the serial bus pins are asynchronous to ref_clk_i and that the test
// clock is slow enough (well under a quarter of ref_clk_i) for edge finding.
//
// Functional notes
// - Next state from TMS at TCK rise.
// - Sample at TCK rise, drive TDO at fall.
// - Sixteen states, six stable, ten unstable.
// - TMS high five cycles reaches reset.
// - Power-up enters reset, test logic disabled.
// - Reset loads instruction 10000001, identification code.
// - Reset sets boundary bits 47 and 46.
// - Reset loads boundary-control with 010.
// - Reset leads through run-test/idle first.
// - Test operation runs only in idle.
// - Select states act nothing, leave next.
// - Capture-data loads on exiting rising edge.
// - Shift-data enables TDO at next fall.
// - TDO first drives scan register LSB.
// - Serial path through instruction or data.
// - Instruction 8, boundary 48, identification 32 bits.
// - Boundary-control 3 bits, bypass 1 bit.
// - Only one register in serial path.
// - One shift per rise, including exiting edge.
// - First exit state floats TDO at fall.
// - Data latches update at fall in update.
// - Capture-instruction 10000001; update at fall.
`timescale 1ns/1ps
`include "bstap_cfg.svh"

module bstap_ctrl
  import bstap_pkg::*;
(
  input  wire logic                    ref_clk_i,     // System clock, 100 MHz.
  input  wire logic                    resetn_i,      // Power-up reset, active low.
  input  wire bstap_pins_t             pins_i,        // Test clock, mode select, data in.
  input  wire logic [`BSTAP_BSR_W-1:0] bsr_capture_i, // Pin levels seen by the boundary cells.
  output logic                         tdo_o,         // Serial test data out.
  output logic                         tdo_oe_n_o,    // Low while TDO is driven.
  output logic [`BSTAP_IR_W-1:0]       instr_o,       // Current instruction.
  output logic [`BSTAP_BSR_W-1:0]      bsr_o,         // Boundary-scan update latches.
  output logic [`BSTAP_BCR_W-1:0]      bcr_o,         // Boundary-control update latches.
  output bstap_state_t                 state_o,       // Controller state.
  output logic                         test_reset_o,  // High in the reset state.
  output logic                         run_op_o       // High while the test operation runs.
);

  // Synchronised copies of the serial bus pins.
  logic [2:0]    pins_sync_raw;
  bstap_pins_t   pins_s;
  logic          tck_prev;       // Last synchronised test clock level.
  wire           tck_rise;       // One-cycle pulse at a test clock rise.
  wire           tck_fall;       // One-cycle pulse at a test clock fall.

  // Controller state and its successor.
  bstap_state_t  state;
  bstap_state_t  next_state;

  // Shift stages of each register.
  logic [`BSTAP_IR_W-1:0]  ir_sh;
  logic [`BSTAP_BSR_W-1:0] bsr_sh;
  logic [`BSTAP_BCR_W-1:0] bcr_sh;
  logic [`BSTAP_ID_W-1:0]  id_sh;
  logic                    byp_sh;

  // Decoded path selection.
  bstap_dr_t     dr_sel;
  wire           in_shift_dr;
  wire           in_shift_ir;
  wire           serial_bit;

  // Pass the three asynchronous pins through two flip-flops each.
  bstap_sync #(
    .W (3)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (pins_i),
    .q_o       (pins_sync_raw)
  );

  assign pins_s = bstap_pins_t'(pins_sync_raw);

  // Remember the previous test clock level for edge finding.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pins_s.tck;
    end
  end

  assign tck_rise = pins_s.tck & ~tck_prev;
  assign tck_fall = ~pins_s.tck & tck_prev;

  // Transition graph
  // Each state has two successors selected by the sampled mode select level.
  always_comb begin
    next_state = state;
    unique case (state)
      BSTAP_TLR:       next_state = pins_s.tms ? BSTAP_TLR : BSTAP_RTI;
      BSTAP_RTI:       next_state = pins_s.tms ? BSTAP_SEL_DR : BSTAP_RTI;
      BSTAP_SEL_DR:    next_state = pins_s.tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
      BSTAP_SEL_IR:    next_state = pins_s.tms ? BSTAP_TLR : BSTAP_CAP_IR;
      BSTAP_CAP_DR:    next_state = pins_s.tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
      BSTAP_SHIFT_DR:  next_state = pins_s.tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
      BSTAP_EXIT1_DR:  next_state = pins_s.tms ? BSTAP_UPDATE_DR : BSTAP_PAUSE_DR;
      BSTAP_PAUSE_DR:  next_state = pins_s.tms ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
      BSTAP_EXIT2_DR:  next_state = pins_s.tms ? BSTAP_UPDATE_DR : BSTAP_SHIFT_DR;
      BSTAP_UPDATE_DR: next_state = pins_s.tms ? BSTAP_SEL_DR : BSTAP_RTI;
      BSTAP_CAP_IR:    next_state = pins_s.tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
      BSTAP_SHIFT_IR:  next_state = pins_s.tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
      BSTAP_EXIT1_IR:  next_state = pins_s.tms ? BSTAP_UPDATE_IR : BSTAP_PAUSE_IR;
      BSTAP_PAUSE_IR:  next_state = pins_s.tms ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
      BSTAP_EXIT2_IR:  next_state = pins_s.tms ? BSTAP_UPDATE_IR : BSTAP_SHIFT_IR;
      BSTAP_UPDATE_IR: next_state = pins_s.tms ? BSTAP_SEL_DR : BSTAP_RTI;
    endcase
  end

  // Power-up enters reset
  // The sixteen codes of the enum are all reachable, so no default is needed.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= BSTAP_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // One data register selected
  // The current instruction picks exactly one data register; unknown codes bypass.
  assign dr_sel = (instr_o == `BSTAP_OP_IDCODE) ? BSTAP_DR_ID :
                  (instr_o == `BSTAP_OP_BCR)    ? BSTAP_DR_BCR :
                  ((instr_o == `BSTAP_OP_SAMPLE) ||
                   (instr_o == `BSTAP_OP_EXTEST)) ? BSTAP_DR_BSR :
                  BSTAP_DR_BYPASS;

  assign in_shift_dr = (state == BSTAP_SHIFT_DR);
  assign in_shift_ir = (state == BSTAP_SHIFT_IR);

  // LSB leads out
  // The instruction register is in the path during an instruction scan, the
  // selected data register otherwise.
  assign serial_bit = in_shift_ir                 ? ir_sh[0]  :
                      (dr_sel == BSTAP_DR_ID)     ? id_sh[0]  :
                      (dr_sel == BSTAP_DR_BSR)    ? bsr_sh[0] :
                      (dr_sel == BSTAP_DR_BCR)    ? bcr_sh[0] :
                      byp_sh;

  // Instruction shift per rise
  // The instruction shift stage also reloads 10000001 in the reset state.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_sh <= `BSTAP_IR_RESET;
    end else if (tck_rise) begin
      if (state == BSTAP_TLR) begin
        ir_sh <= `BSTAP_IR_RESET;
      end else if (state == BSTAP_CAP_IR) begin
        ir_sh <= `BSTAP_IR_CAPTURE;
      end else if (in_shift_ir) begin
        ir_sh <= {pins_s.tdi, ir_sh[`BSTAP_IR_W-1:1]};
      end
    end
  end

  // Data register stages
  // Only the selected data register captures or shifts; the others hold.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bsr_sh <= '0;
      bcr_sh <= `BSTAP_BCR_RESET;
      id_sh  <= `BSTAP_IDCODE;
      byp_sh <= 1'b0;
    end else if (tck_rise && (state == BSTAP_CAP_DR)) begin
      // Capture sources per register.
      if (dr_sel == BSTAP_DR_BSR) begin
        bsr_sh <= bsr_capture_i;
      end
      if (dr_sel == BSTAP_DR_BCR) begin
        bcr_sh <= bcr_o;
      end
      if (dr_sel == BSTAP_DR_ID) begin
        id_sh <= `BSTAP_IDCODE;
      end
      if (dr_sel == BSTAP_DR_BYPASS) begin
        byp_sh <= 1'b0;
      end
    end else if (tck_rise && in_shift_dr) begin
      // Shift one bit from TDI towards TDO.
      if (dr_sel == BSTAP_DR_BSR) begin
        bsr_sh <= {pins_s.tdi, bsr_sh[`BSTAP_BSR_W-1:1]};
      end
      if (dr_sel == BSTAP_DR_BCR) begin
        bcr_sh <= {pins_s.tdi, bcr_sh[`BSTAP_BCR_W-1:1]};
      end
      if (dr_sel == BSTAP_DR_ID) begin
        id_sh <= {pins_s.tdi, id_sh[`BSTAP_ID_W-1:1]};
      end
      if (dr_sel == BSTAP_DR_BYPASS) begin
        byp_sh <= pins_s.tdi;
      end
    end
  end

  // Instruction update at fall
  // The current instruction changes only at a fall while in update-instruction or in the reset state.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr_o <= `BSTAP_IR_RESET;
    end else if (tck_fall) begin
      if (state == BSTAP_TLR) begin
        instr_o <= `BSTAP_IR_RESET;
      end else if (state == BSTAP_UPDATE_IR) begin
        instr_o <= ir_sh;
      end
    end
  end

  // Data update at fall
  // Boundary cells other than the two enable cells clear to zero at power-up only; the reset state leaves them.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bsr_o <= {2'h3, 46'h0};
      bcr_o <= `BSTAP_BCR_RESET;
    end else if (tck_fall) begin
      if (state == BSTAP_TLR) begin
        bsr_o[`BSTAP_BSR_OE_HI] <= 1'b1;
        bsr_o[`BSTAP_BSR_OE_LO] <= 1'b1;
        bcr_o <= `BSTAP_BCR_RESET;
      end else if (state == BSTAP_UPDATE_DR) begin
        if (dr_sel == BSTAP_DR_BSR) begin
          bsr_o <= bsr_sh;
        end
        if (dr_sel == BSTAP_DR_BCR) begin
          bcr_o <= bcr_sh;
        end
      end
    end
  end

  // TDO changes at fall
  // At each fall TDO drives in either shift state and floats elsewhere.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_o      <= serial_bit;
      tdo_oe_n_o <= ~(in_shift_dr | in_shift_ir);
    end
  end

  assign state_o = state;

  assign test_reset_o = (state == BSTAP_TLR);

  assign run_op_o = (state == BSTAP_RTI);

endmodule

/* pkg/bstap_cfg.svh */
// Constants of the boundary-scan test access port controller.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef BSTAP_CFG_SVH
`define BSTAP_CFG_SVH

// Register widths.
`define BSTAP_IR_W        8
`define BSTAP_BSR_W       48
`define BSTAP_BCR_W       3
`define BSTAP_ID_W        32

// Reset and capture values.
`define BSTAP_IR_RESET    8'h81
`define BSTAP_IR_CAPTURE  8'h81
`define BSTAP_BCR_RESET   3'h2
`define BSTAP_BSR_OE_HI   47
`define BSTAP_BSR_OE_LO   46

// Opcodes that steer the data-register path (others select bypass).
`define BSTAP_OP_IDCODE   8'h81
`define BSTAP_OP_SAMPLE   8'h82
`define BSTAP_OP_EXTEST   8'h00
`define BSTAP_OP_BCR      8'h87

// Identification code; the value is arbitrary.
`define BSTAP_IDCODE      32'h0000_0001

// Synchroniser depth in flip-flops.
`define BSTAP_SYNC_DEPTH  2

`endif

/* pkg/bstap_pkg.sv */
// Types of the boundary-scan test access port controller.
// Assumes the constants header is on the include path.
`include "bstap_cfg.svh"

package bstap_pkg;

  // Controller states with binary codes written out.
  typedef enum logic [3:0] {
    BSTAP_TLR        = 4'h0,
    BSTAP_RTI        = 4'h1,
    BSTAP_SEL_DR     = 4'h2,
    BSTAP_CAP_DR     = 4'h3,
    BSTAP_SHIFT_DR   = 4'h4,
    BSTAP_EXIT1_DR   = 4'h5,
    BSTAP_PAUSE_DR   = 4'h6,
    BSTAP_EXIT2_DR   = 4'h7,
    BSTAP_UPDATE_DR  = 4'h8,
    BSTAP_SEL_IR     = 4'h9,
    BSTAP_CAP_IR     = 4'hA,
    BSTAP_SHIFT_IR   = 4'hB,
    BSTAP_EXIT1_IR   = 4'hC,
    BSTAP_PAUSE_IR   = 4'hD,
    BSTAP_EXIT2_IR   = 4'hE,
    BSTAP_UPDATE_IR  = 4'hF
  } bstap_state_t;

  // Data register currently chosen by the instruction.
  typedef enum logic [1:0] {
    BSTAP_DR_BYPASS  = 2'h0,
    BSTAP_DR_ID      = 2'h1,
    BSTAP_DR_BSR     = 2'h2,
    BSTAP_DR_BCR     = 2'h3
  } bstap_dr_t;

  // Serial test bus inputs travelling together.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstap_pins_t;

endpackage

/* design/bstap_sync.sv */
// Two-stage synchroniser for signals that arrive from outside the clock domain.
// Assumes the destination logic reads only the output of the last stage.
`timescale 1ns/1ps

module bstap_sync
  import bstap_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;   // First stage, read only by the second stage.

  // Both stages clear to zero under reset and then follow the input.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

/* tb/bstap_ctrl_asserts.sv */
// Port assertions for the test access port controller.
// Assumes TCK is far slower than ref_clk_i and pins move at ref_clk_i edges.
`timescale 1ns/1ps
`include "bstap_cfg.svh"

module bstap_ctrl_asserts
  import bstap_pkg::*;
(
  input wire logic                    ref_clk_i,
  input wire logic                    resetn_i,
  input wire bstap_pins_t             pins_i,
  input wire logic [`BSTAP_BSR_W-1:0] bsr_capture_i,
  input wire logic                    tdo_o,
  input wire logic                    tdo_oe_n_o,
  input wire logic [`BSTAP_IR_W-1:0]  instr_o,
  input wire logic [`BSTAP_BSR_W-1:0] bsr_o,
  input wire logic [`BSTAP_BCR_W-1:0] bcr_o,
  input wire bstap_state_t            state_o,
  input wire logic                    test_reset_o,
  input wire logic                    run_op_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Successor of a state for a given TMS level.
  function automatic bstap_state_t nxt(bstap_state_t s, logic m);
    case (s)
      BSTAP_TLR:       nxt = m ? BSTAP_TLR : BSTAP_RTI;
      BSTAP_SEL_DR:    nxt = m ? BSTAP_SEL_IR : BSTAP_CAP_DR;
      BSTAP_CAP_DR:    nxt = m ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
      BSTAP_SHIFT_DR:  nxt = m ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
      BSTAP_EXIT1_DR:  nxt = m ? BSTAP_UPDATE_DR : BSTAP_PAUSE_DR;
      BSTAP_PAUSE_DR:  nxt = m ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
      BSTAP_EXIT2_DR:  nxt = m ? BSTAP_UPDATE_DR : BSTAP_SHIFT_DR;
      BSTAP_SEL_IR:    nxt = m ? BSTAP_TLR : BSTAP_CAP_IR;
      BSTAP_CAP_IR:    nxt = m ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
      BSTAP_SHIFT_IR:  nxt = m ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
      BSTAP_EXIT1_IR:  nxt = m ? BSTAP_UPDATE_IR : BSTAP_PAUSE_IR;
      BSTAP_PAUSE_IR:  nxt = m ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
      BSTAP_EXIT2_IR:  nxt = m ? BSTAP_UPDATE_IR : BSTAP_SHIFT_IR;
      default:         nxt = m ? BSTAP_SEL_DR : BSTAP_RTI;
    endcase
  endfunction

  a_state_graph: assert property ($rose(pins_i.tck) |-> ##6
    state_o == nxt($past(state_o, 6), $past(pins_i.tms, 6))) else $error("bad next state");
  a_state_on_rise: assert property ($changed(state_o) |-> pins_i.tck)
    else $error("state moved while TCK low");
  a_tdo_on_fall: assert property (($changed(tdo_o) || $changed(tdo_oe_n_o)) |-> !pins_i.tck)
    else $error("TDO moved while TCK high");
  a_tdo_enable: assert property ($fell(pins_i.tck) && state_o inside {BSTAP_SHIFT_DR,
    BSTAP_SHIFT_IR} |-> ##6 !tdo_oe_n_o) else $error("TDO not driven in shift");
  a_tdo_float: assert property ($fell(pins_i.tck) && !(state_o inside {BSTAP_SHIFT_DR,
    BSTAP_SHIFT_IR}) |-> ##6 tdo_oe_n_o) else $error("TDO driven outside shift");
  a_instr_update: assert property ($changed(instr_o) |-> $past(state_o) inside
    {BSTAP_UPDATE_IR, BSTAP_TLR}) else $error("instruction changed outside update");
  a_latch_update: assert property (($changed(bsr_o) || $changed(bcr_o)) |->
    $past(state_o) inside {BSTAP_UPDATE_DR, BSTAP_TLR}) else $error("latch changed early");
  a_reset_values: assert property ($fell(test_reset_o) |-> instr_o == 8'h81
    && bcr_o == 3'h2 && bsr_o[47:46] == 2'h3) else $error("reset values lost");
  a_reset_flag: assert property (test_reset_o == (state_o == BSTAP_TLR))
    else $error("reset flag wrong");
  a_idle_flag: assert property (run_op_o == (state_o == BSTAP_RTI))
    else $error("operation flag wrong");
endmodule

bind bstap_ctrl bstap_ctrl_asserts bstap_ctrl_asserts_i (.*);

/* tb/bstap_tester.sv */
// Model of the board-level test controller on the serial test bus.
// Assumes one caller at a time; each step is one 160 ns TCK period.
`timescale 1ns/1ps

module bstap_tester
  import bstap_pkg::*;
(
  input  wire logic  ref_clk_i,
  input  wire logic  tdo_i,
  input  wire logic  tdo_oe_n_i,
  output bstap_pins_t pins_o
);
  // The bus idles with TCK low and the pulled-up lines high.
  initial pins_o = 3'h3;

  // One TCK period: low half, sample TDO, then high half.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge ref_clk_i);
    pins_o.tms <= tms;
    pins_o.tdi <= tdi;
    repeat (7) @(posedge ref_clk_i);
    // TDO has no pull resistor, so a floating TDO reads as the inverse of its last level.
    tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;
    pins_o.tck <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    pins_o.tck <= 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the test access port controller.
// Assumes the tester model drives the serial bus and the checker is bound.
`timescale 1ns/1ps
`include "bstap_cfg.svh"

module testbench
  import bstap_pkg::*;
;
  typedef struct {logic [7:0] op; int len; logic [47:0] cap; logic [47:0] din; int kind;}
    bstap_tb_row_t;
  logic                    ref_clk_i = 1'b0;
  logic                    resetn_i  = 1'b0;
  bstap_pins_t             pins;
  logic [`BSTAP_BSR_W-1:0] cap_pins  = 48'h5A3C_9E17_D264;
  logic tdo, tdo_oe_n, run_op_o, test_reset_o;
  logic [7:0]              instr_o;
  logic [47:0]             bsr_o, d;
  logic [2:0]              bcr_o;
  bstap_state_t            state_o;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  // Ordinary scans: opcode, length, expected capture, data shifted in, latch kind.
  bstap_tb_row_t rows[5] = '{
    '{8'h81, 32, `BSTAP_IDCODE, 48'h0, 0},
    '{8'h87, 3, 48'h2, 48'h5, 2},
    '{8'h00, 48, 48'h5A3C_9E17_D264, 48'hC3A5_8765_4321, 1},
    '{8'h82, 48, 48'h5A3C_9E17_D264, 48'h3C5A_1234_9ABC, 1},
    '{8'hFF, 1, 48'h0, 48'h1, 0}};

  always #5 ref_clk_i = ~ref_clk_i;

  bstap_ctrl bstap_ctrl_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pins_i(pins),
    .bsr_capture_i(cap_pins), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .instr_o(instr_o),
    .bsr_o(bsr_o), .bcr_o(bcr_o), .state_o(state_o), .test_reset_o(test_reset_o),
    .run_op_o(run_op_o));
  bstap_tester bstap_tester_i (.ref_clk_i(ref_clk_i), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n),
    .pins_o(pins));

  task automatic summarize();
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic go(input logic m);
    logic t;
    bstap_tester_i.step(m, 1'b1, t);
  endtask

  // Full scan from idle back to idle; ir picks the instruction path.
  task automatic scan(input logic ir, input int n, input logic [47:0] din,
                      output logic [47:0] dout);
    logic b;
    go(1'b1);
    if (ir) go(1'b1);
    go(1'b0);
    go(1'b0);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      bstap_tester_i.step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    go(1'b1);
    go(1'b0);
  endtask

  // Stops a hung run.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(state_o === BSTAP_TLR && test_reset_o === 1'b1, "power-up state");
    chk(tdo_oe_n === 1'b1, "TDO floats");
    chk(instr_o === 8'h81, "reset instruction");
    chk(bsr_o[47:46] === 2'h3, "reset enables");
    chk(bcr_o === 3'h2, "reset control");
    go(1'b0);
    chk(run_op_o === 1'b1, "idle reached");
    foreach (rows[r]) begin
      scan(1'b1, 8, {40'h0, rows[r].op}, d);
      chk(d[7:0] === 8'h81, "instruction capture");
      chk(instr_o === rows[r].op, "instruction update");
      scan(1'b0, rows[r].len, rows[r].din, d);
      chk((d & ((48'h1 << rows[r].len) - 48'h1)) === rows[r].cap, "data capture");
      if (rows[r].kind == 1) chk(bsr_o === rows[r].din, "boundary latch");
      if (rows[r].kind == 2) chk(bcr_o === rows[r].din[2:0], "control latch");
      chk(run_op_o === 1'b1, "back in idle");
    end
    go(1'b1);
    go(1'b0);
    go(1'b0);
    repeat (5) go(1'b1);
    chk(state_o === BSTAP_TLR, "five high reach reset");
    go(1'b1);
    chk(instr_o === 8'h81 && bcr_o === 3'h2, "reset state values");
    chk(bsr_o[47:46] === 2'h3, "reset state enables");
    go(1'b0);
    resetn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(state_o === BSTAP_TLR, "mid-run reset");
    summarize();
  end
endmodule
